/* File: src/vfwm_pkg.sv */
// Shared constants and types for the output-voltage fault and warning monitor.
package vfwm_pkg;
  // ---------------------------------------------------------------
  // Command codes and response byte layout.
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OV_RESP  = 8'h41;
  localparam logic [7:0] CMD_OV_WARN  = 8'h42;
  localparam logic [7:0] CMD_UV_WARN  = 8'h43;
  localparam logic [7:0] CMD_UV_FAULT = 8'h44;
  localparam int         ACT_POS      = 6;
  localparam int         CNT_POS      = 3;
  localparam int         MUL_POS      = 0;
  localparam logic [1:0] ACT_IGNORE   = 2'h0;
  localparam logic [1:0] ACT_INVALID  = 2'h3;
  localparam logic [2:0] CNT_LATCH    = 3'h0;
  localparam logic [2:0] CNT_FOREVER  = 3'h7;
  localparam logic [2:0] MUL_SINGLE   = 3'h0;
  // ---------------------------------------------------------------
  // Threshold steps in half-percent units of the output target.
  // ---------------------------------------------------------------
  localparam logic [7:0]  PCT_SCALE  = 8'hc8;
  localparam logic [15:0] REL_ONE    = 16'h00c8;
  localparam logic [7:0]  OVW_FIRST  = 8'hce;
  localparam logic [7:0]  UVW_FIRST  = 8'ha8;
  localparam logic [7:0]  WARN_STEP  = 8'h02;
  localparam int          WARN_COUNT = 14;
  localparam logic [7:0]  UVF_FIRST  = 8'h78;
  localparam logic [7:0]  UVF_STEP   = 8'h05;
  localparam int          UVF_COUNT  = 15;
  // ---------------------------------------------------------------
  // Values after reset.
  // ---------------------------------------------------------------
  localparam logic [7:0]  RESP_RST     = 8'h80;
  localparam logic [15:0] OVW_RST      = 16'h00dc;
  localparam logic [15:0] UVW_RST      = 16'h00b4;
  localparam logic [15:0] UVF_RST      = 16'h0096;
  localparam logic [3:0]  OVW_STEP_RST = 4'h7;
  localparam logic [3:0]  UVW_STEP_RST = 4'h6;
  localparam logic [3:0]  UVF_STEP_RST = 4'h6;
  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'h01, ST_RAMP = 5'h02, ST_RUN = 5'h04, ST_HICCUP = 5'h08, ST_LATCH = 5'h10
  } vfwm_state_e;
  typedef struct packed {
    logic [1:0] action;
    logic [2:0] restarts;
    logic [2:0] mult;
  } vfwm_resp_s;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } vfwm_cmd_s;
  typedef struct packed {
    logic byte_ov;
    logic word_vout;
    logic ov_fault;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
    logic invalid;
  } vfwm_status_s;
  typedef struct packed {
    vfwm_state_e  state;
    vfwm_resp_s   resp;
    logic [15:0]  ovw_word;
    logic [15:0]  uvw_word;
    logic [15:0]  uvf_word;
    logic [3:0]   ovw_step;
    logic [3:0]   uvw_step;
    logic [3:0]   uvf_step;
    logic [2:0]   retry;
    logic         attempt;
    vfwm_status_s stat;
    logic         alert_n;
    logic [15:0]  rd_data;
    logic         rd_valid;
    logic         out_en;
    logic         blocked;
    logic         uv_prev;
    logic         uv_evt;
  } vfwm_core_s;
  localparam vfwm_core_s CORE_RST = '{state: ST_OFF, resp: RESP_RST, ovw_word: OVW_RST, uvw_word: UVW_RST,
                                      uvf_word: UVF_RST, ovw_step: OVW_STEP_RST, uvw_step: UVW_STEP_RST,
                                      uvf_step: UVF_STEP_RST, alert_n: 1'b1, default: '0};

  // Percentage of step k in half-percent units.
  function automatic logic [7:0] vfwm_pct(input logic [7:0] first, input logic [7:0] step, input logic [3:0] k);
    return first + step * {4'h0, k};
  endfunction : vfwm_pct
endpackage : vfwm_pkg

/* File: src/vfwm_step_map.sv */
// Maps a written limit word onto a supported percentage step, rounding up or down as ROUND_UP selects.
`timescale 1ns/1ps
`default_nettype none
module vfwm_step_map #(
  parameter logic [7:0] FIRST    = 8'hce,
  parameter logic [7:0] STEP     = 8'h02,
  parameter int         COUNT    = 14,
  parameter bit         ROUND_UP = 1'b1
) (
  input  wire logic [15:0] limit,
  input  wire logic [15:0] ref_val,
  output logic      [3:0]  step,
  output logic             valid
);
  import vfwm_pkg::*;
  logic [24:0]      lim_s;
  logic [24:0]      prod [COUNT];
  logic [COUNT-1:0] below;
  logic [COUNT-1:0] atmost;
  logic [3:0]       n_below;
  logic [3:0]       n_atmost;

  assign lim_s = 25'(limit) * 25'(PCT_SCALE);
  for (genvar k = 0; k < COUNT; k++) begin : g_step
    assign prod[k]   = 25'(ref_val) * 25'(vfwm_pct(FIRST, STEP, 4'(k)));
    assign below[k]  = prod[k] < lim_s;
    assign atmost[k] = prod[k] <= lim_s;
  end

  always_comb begin
    n_below  = '0;
    n_atmost = '0;
    for (int i = 0; i < COUNT; i++) begin
      n_below  = n_below + 4'(below[i]);
      n_atmost = n_atmost + 4'(atmost[i]);
    end
    step  = ROUND_UP ? n_below : n_atmost - 4'h1;
    valid = atmost[0] && (prod[COUNT-1] >= lim_s);
  end
endmodule : vfwm_step_map
`default_nettype wire

/* File: src/vfwm_timer.sv */
// Down-counting one-shot timer for hiccup periods and success windows.
`timescale 1ns/1ps
`default_nettype none
module vfwm_timer #(
  parameter int W = 19
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic         abort,
  input  wire logic [W-1:0] value,
  output logic              done,
  output logic              busy
);
  import vfwm_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } vfwm_tmr_s;
  vfwm_tmr_s q;
  vfwm_tmr_s d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (load) begin
      d.cnt  = (value == '0) ? W'(1) : value;
      d.busy = 1'b1;
    end else if (abort) begin
      d.cnt  = '0;
      d.busy = 1'b0;
    end else if (q.busy) begin
      if (q.cnt == W'(1)) begin
        d.cnt  = '0;
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign done = q.done;
  assign busy = q.busy;
endmodule : vfwm_timer
`default_nettype wire

/* File: src/vfwm_monitor.sv */
// Output-voltage fault response, warning limits and restart control.
`timescale 1ns/1ps
`default_nettype none
module vfwm_monitor #(
  parameter int TW = 19
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire vfwm_pkg::vfwm_cmd_s   cmd,
  output logic               [15:0]  rd_data,
  output logic                       rd_valid,
  input  wire logic                  rel_mode,
  input  wire logic          [15:0]  vout_target,
  input  wire logic          [15:0]  vout_sense,
  input  wire logic                  ov_fault_in,
  input  wire logic                  shut_fault_in,
  input  wire logic                  conv_enable,
  input  wire logic                  ramp_done,
  input  wire logic                  ton_max_en,
  input  wire logic                  ton_max_done,
  input  wire logic          [15:0]  ton_rise_cycles,
  input  wire logic                  clear_faults,
  output vfwm_pkg::vfwm_status_s     status,
  output logic                       alert_n,
  output logic                       out_en,
  output logic                       start_blocked,
  output logic                       latched_off,
  output logic               [2:0]   restart_used,
  output logic                       uv_fault_evt
);
  import vfwm_pkg::*;
  // ---------------------------------------------------------------
  // Limit mapping and comparison.
  // ---------------------------------------------------------------
  vfwm_core_s   q;
  vfwm_core_s   d;
  vfwm_status_s set;
  logic [15:0]  map_ref;
  logic [3:0]   ovw_map;
  logic [3:0]   uvw_map;
  logic [3:0]   uvf_map;
  logic         ovw_ok;
  logic         uvw_ok;
  logic         uvf_ok;
  logic [24:0]  sense_s;
  logic [24:0]  ovw_thr;
  logic [24:0]  uvw_thr;
  logic [24:0]  uvf_thr;
  logic         ovw_hit;
  logic         uvw_hit;
  logic         uvf_hit;
  logic         ov_trip;
  logic [3:0]   fails;
  logic [2:0]   mult_eff;
  logic [TW-1:0] hic_len;
  logic         tmr_load;
  logic         tmr_abort;
  logic [TW-1:0] tmr_val;
  logic         tmr_done;
  logic         tmr_busy;

  assign map_ref = rel_mode ? REL_ONE : vout_target;

  vfwm_step_map #(.FIRST(OVW_FIRST), .STEP(WARN_STEP), .COUNT(WARN_COUNT), .ROUND_UP(1'b1)) u_ovw_map (
    .limit   (cmd.wdata),
    .ref_val (map_ref),
    .step    (ovw_map),
    .valid   (ovw_ok)
  );
  vfwm_step_map #(.FIRST(UVW_FIRST), .STEP(WARN_STEP), .COUNT(WARN_COUNT), .ROUND_UP(1'b0)) u_uvw_map (
    .limit   (cmd.wdata),
    .ref_val (map_ref),
    .step    (uvw_map),
    .valid   (uvw_ok)
  );
  vfwm_step_map #(.FIRST(UVF_FIRST), .STEP(UVF_STEP), .COUNT(UVF_COUNT), .ROUND_UP(1'b0)) u_uvf_map (
    .limit   (cmd.wdata),
    .ref_val (map_ref),
    .step    (uvf_map),
    .valid   (uvf_ok)
  );

  assign sense_s = 25'(vout_sense) * 25'(PCT_SCALE);
  assign ovw_thr = 25'(vout_target) * 25'(vfwm_pct(OVW_FIRST, WARN_STEP, q.ovw_step));
  assign uvw_thr = 25'(vout_target) * 25'(vfwm_pct(UVW_FIRST, WARN_STEP, q.uvw_step));
  assign uvf_thr = 25'(vout_target) * 25'(vfwm_pct(UVF_FIRST, UVF_STEP, q.uvf_step));
  assign ovw_hit = sense_s > ovw_thr;
  assign uvw_hit = (q.state == ST_RUN) && (sense_s < uvw_thr);
  assign uvf_hit = (q.state == ST_RUN) && (sense_s < uvf_thr);
  assign ov_trip = ov_fault_in && (q.resp.action != ACT_IGNORE);
  assign fails    = 4'(q.retry) + 4'(q.attempt);
  assign mult_eff = (q.resp.mult == MUL_SINGLE) ? 3'h1 : q.resp.mult;
  assign hic_len  = TW'(ton_rise_cycles) * TW'(mult_eff);

  vfwm_timer #(.W(TW)) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .abort    (tmr_abort),
    .value    (tmr_val),
    .done     (tmr_done),
    .busy     (tmr_busy)
  );

  // ---------------------------------------------------------------
  // Commands, status and restart sequencing.
  // ---------------------------------------------------------------
  always_comb begin
    d          = q;
    set        = '0;
    tmr_load   = 1'b0;
    tmr_abort  = 1'b0;
    tmr_val    = '0;
    d.rd_valid = 1'b0;
    if (cmd.valid && cmd.write) begin
      case (cmd.code)
        CMD_OV_RESP: begin
          if (cmd.wdata[7:6] != ACT_INVALID) d.resp = vfwm_resp_s'(cmd.wdata[7:0]);
          else set.invalid = 1'b1;
        end
        CMD_OV_WARN: begin
          if (ovw_ok) begin
            d.ovw_word = cmd.wdata;
            d.ovw_step = ovw_map;
          end else set.invalid = 1'b1;
        end
        CMD_UV_WARN: begin
          if (uvw_ok) begin
            d.uvw_word = cmd.wdata;
            d.uvw_step = uvw_map;
          end else set.invalid = 1'b1;
        end
        CMD_UV_FAULT: begin
          if (uvf_ok) begin
            d.uvf_word = cmd.wdata;
            d.uvf_step = uvf_map;
          end else set.invalid = 1'b1;
        end
        default: ;
      endcase
    end else if (cmd.valid) begin
      d.rd_valid = 1'b1;
      case (cmd.code)
        CMD_OV_RESP:  d.rd_data = {8'h00, q.resp};
        CMD_OV_WARN:  d.rd_data = q.ovw_word;
        CMD_UV_WARN:  d.rd_data = q.uvw_word;
        CMD_UV_FAULT: d.rd_data = q.uvf_word;
        default:      d.rd_valid = 1'b0;
      endcase
    end
    set.byte_ov   = ov_fault_in;
    set.ov_fault  = ov_fault_in;
    set.ov_warn   = ovw_hit;
    set.uv_warn   = uvw_hit;
    set.uv_fault  = uvf_hit;
    set.word_vout = ov_fault_in | ovw_hit | uvw_hit | uvf_hit;
    d.uv_prev     = uvf_hit;
    d.uv_evt      = uvf_hit & ~q.uv_prev;
    case (q.state)
      ST_OFF: begin
        d.out_en  = 1'b0;
        d.retry   = '0;
        d.attempt = 1'b0;
        d.blocked = 1'b0;
        if (conv_enable) begin
          if (ov_fault_in && q.resp.action == ACT_IGNORE) begin
            d.blocked = 1'b1;
          end else begin
            d.state  = ST_RAMP;
            d.out_en = 1'b1;
          end
        end
      end
      ST_RAMP, ST_RUN: begin
        if (!conv_enable) begin
          d.state   = ST_OFF;
          d.out_en  = 1'b0;
          tmr_abort = 1'b1;
        end else if (ov_trip) begin
          d.out_en  = 1'b0;
          tmr_abort = 1'b1;
          d.attempt = 1'b0;
          d.retry   = (fails > 4'h7) ? 3'h7 : fails[2:0];
          if (q.resp.restarts == CNT_LATCH) begin
            d.state = ST_LATCH;
          end else if (q.resp.restarts == CNT_FOREVER || fails < 4'(q.resp.restarts)) begin
            d.state  = ST_HICCUP;
            tmr_load = 1'b1;
            tmr_val  = hic_len;
          end else begin
            d.state = ST_LATCH;
          end
        end else if (q.state == ST_RAMP) begin
          if (ton_max_en ? ton_max_done : ramp_done) begin
            d.state  = ST_RUN;
            tmr_load = 1'b1;
            tmr_val  = TW'(ton_rise_cycles);
          end
        end else if (shut_fault_in) begin
          tmr_abort = 1'b1;
        end else if (tmr_done) begin
          d.retry   = '0;
          d.attempt = 1'b0;
        end
      end
      ST_HICCUP: begin
        if (!conv_enable) begin
          d.state   = ST_OFF;
          tmr_abort = 1'b1;
        end else if (tmr_done) begin
          d.state   = ST_RAMP;
          d.out_en  = 1'b1;
          d.attempt = 1'b1;
        end
      end
      ST_LATCH: begin
        d.out_en = 1'b0;
        if (!conv_enable) d.state = ST_OFF;
      end
      default: begin
        d.state  = ST_OFF;
        d.out_en = 1'b0;
      end
    endcase
    d.stat    = vfwm_status_s'((q.stat & ~{7{clear_faults}}) | set);
    d.alert_n = ~|d.stat;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= CORE_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign rd_data       = q.rd_data;
  assign rd_valid      = q.rd_valid;
  assign status        = q.stat;
  assign alert_n       = q.alert_n;
  assign out_en        = q.out_en;
  assign start_blocked = q.blocked;
  assign latched_off   = (q.state == ST_LATCH);
  assign restart_used  = q.retry;
  assign uv_fault_evt  = q.uv_evt;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  logic [19:0]   hic_cyc_h;
  logic [TW-1:0] hic_len_h;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hic_cyc_h <= '0;
      hic_len_h <= '0;
    end else if (clk_en) begin
      hic_cyc_h <= (q.state == ST_HICCUP && d.state == ST_HICCUP) ? hic_cyc_h + 20'h1 : '0;
      if (tmr_load) hic_len_h <= tmr_val;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  sequence s_run_trip;
    (q.state == ST_RUN || q.state == ST_RAMP) && conv_enable && ov_trip;
  endsequence
  sequence s_hiccup_end;
    q.state == ST_HICCUP && conv_enable && tmr_done;
  endsequence

  chk_invalid_action: assert property (cmd.valid && cmd.write && cmd.code == CMD_OV_RESP && cmd.wdata[7:6] == ACT_INVALID
      |=> q.resp == $past(q.resp) && status.invalid && !alert_n)
    else $error("Invalid action code was accepted.");
  chk_latch_zero: assert property (s_run_trip ##0 q.resp.restarts == CNT_LATCH |=> latched_off && !out_en)
    else $error("Zero restart count did not latch off.");
  chk_retry_limit: assert property (s_run_trip ##0 q.resp.restarts != CNT_FOREVER && fails >= 4'(q.resp.restarts)
      |=> latched_off && restart_used == $past(q.resp.restarts))
    else $error("Restart limit not honoured.");
  chk_forever_retry: assert property (s_run_trip ##0 q.resp.restarts == CNT_FOREVER |=> q.state == ST_HICCUP)
    else $error("Unlimited retry did not enter hiccup.");
  chk_hiccup_len: assert property (s_hiccup_end |-> hic_cyc_h == 20'(hic_len_h) ##1 out_en && q.state == ST_RAMP)
    else $error("Hiccup period length wrong.");
  chk_success_clear: assert property (q.state == ST_RUN && conv_enable && !ov_trip && !shut_fault_in && tmr_done
      |=> restart_used == 3'h0)
    else $error("Successful start did not clear counter.");
  chk_start_block: assert property (q.state == ST_OFF && conv_enable && ov_fault_in && q.resp.action == ACT_IGNORE
      |=> !out_en && start_blocked && q.state == ST_OFF)
    else $error("Start-up allowed with ignored fault present.");
  chk_ov_warn: assert property (ovw_hit |=> status.ov_warn && status.word_vout && !alert_n)
    else $error("Overvoltage warning not flagged.");
  chk_uv_warn: assert property (uvw_hit |=> status.uv_warn && status.word_vout && !alert_n)
    else $error("Undervoltage warning not flagged.");
  chk_ov_fault: assert property (ov_fault_in |=> status.byte_ov && status.ov_fault && status.word_vout)
    else $error("Overvoltage fault flags missing.");
  chk_step_range: assert property (q.ovw_step < 4'(WARN_COUNT) && q.uvf_step < 4'(UVF_COUNT))
    else $error("Threshold step out of range.");
  chk_target_hold: assert property ($changed(vout_target) && !(cmd.valid && cmd.write)
      |=> q.ovw_word == $past(q.ovw_word) && q.uvw_word == $past(q.uvw_word))
    else $error("Stored limit changed with target.");

  sequence s_uv_drop;
    uvf_hit && !q.uv_prev;
  endsequence
  sequence s_bad_uvf_write;
    cmd.valid && cmd.write && cmd.code == CMD_UV_FAULT && !uvf_ok;
  endsequence
  sequence s_ov_word_read;
    cmd.valid && !cmd.write && cmd.code == CMD_OV_WARN;
  endsequence

  chk_uv_event: assert property (s_uv_drop |=> uv_fault_evt && status.uv_fault && !alert_n)
    else $error("Undervoltage fault event missing.");
  chk_uvf_refuse: assert property (s_bad_uvf_write |=> $stable(q.uvf_word) && status.invalid)
    else $error("Out-of-range undervoltage fault limit accepted.");
  chk_word_read: assert property (s_ov_word_read |=> rd_valid && rd_data == $past(q.ovw_word))
    else $error("Limit word read back wrong.");
  chk_off_command: assert property (!conv_enable |=> q.state == ST_OFF && !out_en)
    else $error("Output not off after disable.");
endmodule : vfwm_monitor
`default_nettype wire

/* File: tb/vfwm_host_model.sv */
// Host side model that turns bench requests into decoded command strobes.
`timescale 1ns/1ps
`default_nettype none
module vfwm_host_model
  import vfwm_pkg::*;
(
  input  wire vfwm_pkg::vfwm_cmd_s req,
  output vfwm_pkg::vfwm_cmd_s      cmd
);
  // ---------------------------------------------------------------
  // Command shaping.
  // ---------------------------------------------------------------
  // Byte commands carry only the low byte; limit words go whole as 16 bits.
  always_comb begin
    cmd = req;
    if (req.code == CMD_OV_RESP) begin
      cmd.wdata = {8'h00, req.wdata[7:0]};
    end
  end
  // Fault-limit writes pass unchanged; start-up blocking depends on conv_enable, ov_fault_in and the response action.
endmodule : vfwm_host_model
`default_nettype wire

/* File: tb/vfwm_monitor_test.sv */
// Self-checking bench for the output-voltage monitor.
`timescale 1ns/1ps
`default_nettype none
module vfwm_monitor_test;
  import vfwm_pkg::*;
  logic         core_clk, rst, clk_en, conv_enable, ramp_done, ov_fault_in, shut_fault_in, clear_faults;
  logic         rd_valid, alert_n, out_en, start_blocked, latched_off, uv_fault_evt;
  logic [2:0]   restart_used;
  logic         rel_mode, ton_max_en, ton_max_done;
  logic [15:0]  vout_sense, vout_target, rd_data, exp_w;
  vfwm_cmd_s    req, cmd;
  vfwm_status_s status;
  logic [15:0]  exp_q[$];
  int           error_cnt, n_tests, i;

  vfwm_host_model i_host (.req(req), .cmd(cmd));
  vfwm_monitor i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cmd(cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .rel_mode(rel_mode), .vout_target(vout_target), .vout_sense(vout_sense),
    .ov_fault_in(ov_fault_in), .shut_fault_in(shut_fault_in), .conv_enable(conv_enable), .ramp_done(ramp_done),
    .ton_max_en(ton_max_en), .ton_max_done(ton_max_done), .ton_rise_cycles(16'h0004), .clear_faults(clear_faults),
    .status(status), .alert_n(alert_n), .out_en(out_en), .start_blocked(start_blocked),
    .latched_off(latched_off), .restart_used(restart_used), .uv_fault_evt(uv_fault_evt));

  // ---------------------------------------------------------------
  // Clock, watchdog and shared tasks.
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    cyc(1);
    req = '{1'b1, w, c, d};
    cyc(1);
    req.valid = 1'b0;
  endtask : op
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, c, 16'h0000);
  endtask : rd
  // Waits a bounded time for out_en to reach v; i holds the cycles spent.
  task automatic wait_on(input logic v);
    for (i = 0; i < 40 && out_en !== v; i++) cyc(1);
    chk("out_en", out_en, v);
  endtask : wait_on
  task automatic start;
    conv_enable = 1'b1;
    wait_on(1'b1);
    ramp_done = 1'b1;
    cyc(1);
    ramp_done = 1'b0;
  endtask : start
  task automatic trip;
    ov_fault_in = 1'b1;
    cyc(1);
    ov_fault_in = 1'b0;
    cyc(2);
  endtask : trip
  task automatic stop;
    conv_enable = 1'b0;
    cyc(3);
  endtask : stop
  // Clears the sticky flags while no condition is present, then expects them all low.
  task automatic clr;
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(1);
    chk("cleared", {9'h000, status}, 16'h0000);
    chk("alert_n", alert_n, 1'b1);
  endtask : clr

  // Read answers are compared against the oldest pending note.
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() != 0) chk("rd_data", rd_data, exp_q.pop_front());
      else chk("rd_pending", 16'h0000, 16'h0001);
    end
  end

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    {rst, conv_enable, ramp_done, ov_fault_in, shut_fault_in, clear_faults} = 6'h20;
    clk_en = 1'b1;
    {rel_mode, ton_max_en, ton_max_done, vout_target} = {3'h4, 16'h03e8};
    vout_sense = 16'h03e8;
    req = '0;
    error_cnt = 0;
    n_tests = 0;
    i = $urandom(53);
    cyc(20);
    rst = 1'b0;
    rd(CMD_OV_RESP, {8'h00, RESP_RST});
    rd(CMD_OV_WARN, OVW_RST);
    rd(CMD_UV_WARN, UVW_RST);
    rd(CMD_UV_FAULT, UVF_RST);
    op(1'b1, CMD_OV_RESP, 16'h00c0);
    cyc(1);
    chk("invalid", status.invalid, 1'b1);
    chk("alert_n", alert_n, 1'b0);
    rd(CMD_OV_RESP, 16'h0080);
    op(1'b1, CMD_OV_WARN, 16'h00cd);
    rd(CMD_OV_WARN, OVW_RST);
    op(1'b1, CMD_UV_WARN, 16'h00c3);
    rd(CMD_UV_WARN, UVW_RST);
    op(1'b1, CMD_UV_FAULT, 16'h00c0);
    rd(CMD_UV_FAULT, UVF_RST);
    exp_w = 16'h00ce + 16'($urandom_range(8'h1a));
    op(1'b1, CMD_OV_WARN, exp_w);
    rd(CMD_OV_WARN, exp_w);
    vout_sense = 16'h04b0;
    cyc(2);
    chk("ov_warn", status.ov_warn, 1'b1);
    chk("word_vout", status.word_vout, 1'b1);
    vout_sense = 16'h03e8;
    clr();
    rel_mode = 1'b0;
    op(1'b1, CMD_OV_WARN, 16'h040d);
    vout_target = 16'h07d0;
    rd(CMD_OV_WARN, 16'h040d);
    vout_sense = 16'h0816;
    cyc(2);
    chk("ov_warn", status.ov_warn, 1'b0);
    vout_sense = 16'h082a;
    cyc(2);
    chk("ov_warn", status.ov_warn, 1'b1);
    {rel_mode, vout_target, vout_sense} = {1'b1, 16'h03e8, 16'h03e8};
    clr();
    op(1'b1, CMD_OV_RESP, 16'h0000);
    ov_fault_in = 1'b1;
    conv_enable = 1'b1;
    cyc(2);
    chk("start_blocked", start_blocked, 1'b1);
    chk("out_en", out_en, 1'b0);
    ov_fault_in = 1'b0;
    stop();
    clr();
    op(1'b1, CMD_OV_RESP, 16'h0040);
    start();
    trip();
    chk("latched_off", latched_off, 1'b1);
    chk("ov_fault", status.ov_fault, 1'b1);
    chk("byte_ov", status.byte_ov, 1'b1);
    stop();
    chk("latched_off", latched_off, 1'b0);
    op(1'b1, CMD_OV_RESP, 16'h0048);
    start();
    trip();
    wait_on(1'b1);
    trip();
    chk("latched_off", latched_off, 1'b1);
    stop();
    op(1'b1, CMD_OV_RESP, 16'h007a);
    start();
    trip();
    chk("out_en", out_en, 1'b0);
    wait_on(1'b1);
    // Output stays off from the cycle after the trip through the end of an 8-cycle hiccup: 9 cycles.
    chk("hiccup", 16'(i) + 16'h0002, 16'h0009);
    trip();
    chk("restart_used", {13'h0000, restart_used}, 16'h0001);
    chk("latched_off", latched_off, 1'b0);
    wait_on(1'b1);
    ramp_done = 1'b1;
    cyc(1);
    ramp_done = 1'b0;
    shut_fault_in = 1'b1;
    cyc(1);
    shut_fault_in = 1'b0;
    cyc(6);
    chk("restart_used", {13'h0000, restart_used}, 16'h0001);
    trip();
    chk("restart_used", {13'h0000, restart_used}, 16'h0002);
    wait_on(1'b1);
    ton_max_en = 1'b1;
    ramp_done = 1'b1;
    cyc(1);
    ramp_done = 1'b0;
    cyc(6);
    chk("restart_used", {13'h0000, restart_used}, 16'h0002);
    ton_max_done = 1'b1;
    cyc(1);
    ton_max_done = 1'b0;
    cyc(2);
    chk("restart_used", {13'h0000, restart_used}, 16'h0002);
    cyc(3);
    chk("restart_used", {13'h0000, restart_used}, 16'h0000);
    ton_max_en = 1'b0;
    vout_sense = 16'h0352;
    cyc(2);
    chk("uv_warn", status.uv_warn, 1'b1);
    vout_sense = 16'h02bc;
    cyc(1);
    chk("uv_fault_evt", uv_fault_evt, 1'b1);
    chk("uv_fault", status.uv_fault, 1'b1);
    cyc(1);
    chk("uv_fault_evt", uv_fault_evt, 1'b0);
    vout_sense = 16'h03e8;
    stop();
    chk("pending", 16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule : vfwm_monitor_test
`default_nettype wire
